// ==== core/fgt_top.v ====
// Per-channel counter/timer and control I/O block, APB register slave.
// Assumes camera valids and pins are asynchronous; acquisition inputs are
// on I_MCLK.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "fgt_map.vh"
module fgt_top #(
  parameter CAM_BITS = 4,
  parameter CW = 32,
  parameter TICK_CYCLES = `FGT_TICK_CYCLES
) (
  input wire I_MCLK, // 125 MHz block clock
  input wire I_RESET_N, // Async reset, active low
  input wire I_PSEL, // APB select
  input wire I_PENABLE, // APB enable
  input wire I_PWRITE, // APB direction
  input wire [7:0] I_PADDR, // APB byte address
  input wire [31:0] I_PWDATA, // APB write data
  output reg [31:0] O_PRDATA, // APB read data
  output reg O_PREADY, // APB ready
  output reg O_PSLVERR, // APB error on unmapped address
  input wire I_LINE_VALID, // Camera line valid, async
  input wire I_FRAME_VALID, // Camera frame valid, async
  input wire I_ISOLATED_INPUT_A, // Isolated input, async
  input wire [1:0] I_DIFF_AUX_INPUT, // Differential aux inputs, async
  input wire I_ACQ_ACTIVE, // Acquisition in progress, level
  input wire I_ACQ_DONE, // Acquisition complete, pulse
  input wire I_FIFO_OVERFLOW, // Data FIFO overflow, pulse
  output reg [CAM_BITS-1:0] O_CAM_CTRL, // Camera control port
  output reg O_EXPOSURE_SYNC_OUTPUT, // Exposure monostable A
  output reg O_PIXEL_RESET_OUTPUT, // Exposure monostable B
  output reg O_ISOLATED_OUTPUT_A, // Isolated output
  output reg O_LINE_RATE, // Astable pulse, one cycle
  output reg O_ACQ_TRIGGER, // Delayed acquisition trigger pulse
  output reg O_IRQ // Interrupt, active high level
);

  localparam [31:0] PRE_LAST = TICK_CYCLES - 1;
  localparam [7:0] PRE_MAX = PRE_LAST[7:0];
  localparam [1:0] EVT_LINES = 2'h0;
  localparam [1:0] EVT_FRAMES = 2'h1;
  localparam [1:0] EVT_MICROS = 2'h2;

  function sel4;
    input [1:0] s;
    input a;
    input b;
    input c;
    input d;
    begin
      case (s)
        2'h0: sel4 = a;
        2'h1: sel4 = b;
        2'h2: sel4 = c;
        default: sel4 = d;
      endcase
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      case (a)
        `FGT_OFF_CTRL, `FGT_OFF_AST_PERIOD, `FGT_OFF_MONO_A_WIDTH,
        `FGT_OFF_MONO_B_WIDTH, `FGT_OFF_DELAY_COUNT, `FGT_OFF_EVT_CURRENT,
        `FGT_OFF_EVT_FINAL, `FGT_OFF_CAM_OUT, `FGT_OFF_ISO_OUT,
        `FGT_OFF_IN_STATUS, `FGT_OFF_IRQ_STATUS, `FGT_OFF_IRQ_MASK,
        `FGT_OFF_SW_CMD: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Software-visible state
  reg [31:0] ctrl_r;
  reg [CW-1:0] ast_period_r;
  reg [CW-1:0] mono_a_width_r;
  reg [CW-1:0] mono_b_width_r;
  reg [CW-1:0] delay_count_r;
  reg [7:0] cam_out_r;
  reg [2:0] iso_out_r;
  reg [7:0] irq_status_r;
  reg [7:0] irq_mask_r;
  reg sw_fire_r;
  reg sw_trig_r;

  // Timebase and input conditioning
  reg [7:0] pre_r;
  reg tick_r;
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] prev_r;
  reg trig_prev_r;
  reg gate_prev_r;
  reg [CW-1:0] evt_cur_r;
  reg [CW-1:0] evt_final_r;
  reg [31:0] rd_nxt;

  wire [4:0] pin_in = {I_DIFF_AUX_INPUT, I_ISOLATED_INPUT_A, I_FRAME_VALID, I_LINE_VALID};
  wire lval = sync2_r[0];
  wire fval = sync2_r[1];
  wire iso_in = sync2_r[2];
  wire [1:0] aux_in = sync2_r[4:3];
  wire line_start = lval & ~prev_r[0];
  wire line_end = ~lval & prev_r[0];
  wire frame_start = fval & ~prev_r[1];
  wire frame_end = ~fval & prev_r[1];

  wire ast_en = ctrl_r[`FGT_CTRL_AST_EN];
  wire [1:0] mono_sel = ctrl_r[`FGT_CTRL_MONO_SEL_LO+1:`FGT_CTRL_MONO_SEL_LO];
  wire dly_lines = ctrl_r[`FGT_CTRL_DLY_LINES];
  wire dly_en = ctrl_r[`FGT_CTRL_DLY_EN];
  wire [1:0] evt_sel = ctrl_r[`FGT_CTRL_EVT_SEL_LO+1:`FGT_CTRL_EVT_SEL_LO];
  wire [1:0] gate_sel = ctrl_r[`FGT_CTRL_GATE_SEL_LO+1:`FGT_CTRL_GATE_SEL_LO];
  wire [1:0] trig_src = ctrl_r[`FGT_CTRL_TRIG_SRC_LO+1:`FGT_CTRL_TRIG_SRC_LO];
  wire trig_edge = ctrl_r[`FGT_CTRL_TRIG_EDGE];
  wire trig_inv = ctrl_r[`FGT_CTRL_TRIG_INV];

  wire ast_busy;
  wire ast_pulse;
  wire mono_a;
  wire mono_b;
  wire dly_busy;
  wire dly_done;

  wire trig_lvl = sel4(trig_src, iso_in, aux_in[0], aux_in[1], ast_pulse) ^ trig_inv;
  wire raw_trig = (trig_edge ? (trig_lvl & ~trig_prev_r) : trig_lvl) | sw_trig_r;
  wire dly_used = dly_en & (delay_count_r != {CW{1'b0}});
  wire trig_drop = raw_trig & dly_used & dly_busy;
  wire acq_trig = dly_used ? dly_done : raw_trig;
  wire mono_fire = sel4(mono_sel, acq_trig, ast_pulse, raw_trig, sw_fire_r);
  wire gate = sel4(gate_sel, lval, fval, trig_lvl, I_ACQ_ACTIVE);
  wire evt = (evt_sel == EVT_FRAMES) ? frame_start :
             (evt_sel == EVT_MICROS) ? tick_r : line_start;

  wire apb_setup = I_PSEL & ~I_PENABLE;
  wire apb_wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire [7:0] irq_set = {trig_drop, acq_trig, line_end, line_start,
                        frame_end, frame_start, I_FIFO_OVERFLOW, I_ACQ_DONE};
  wire [7:0] irq_clr = (apb_wr && I_PADDR == `FGT_OFF_IRQ_STATUS) ? I_PWDATA[7:0] : 8'h00;

  // Microsecond tick
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pre_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (pre_r == PRE_MAX) begin
      pre_r <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // Two-flop synchronisers and edge history
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prev_r <= 5'h00;
      trig_prev_r <= 1'b0;
      gate_prev_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      trig_prev_r <= trig_lvl;
      gate_prev_r <= gate;
    end
  end

  // Astable: periodic pulse every period microseconds
  fgt_timer #(.CW(CW)) u_astable (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_tick(tick_r),
    .i_start(ast_en),
    .i_periodic(ast_en),
    .i_load(ast_period_r),
    .o_busy(ast_busy),
    .o_done(ast_pulse)
  );

  fgt_timer #(.CW(CW)) u_mono_a (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_tick(tick_r),
    .i_start(mono_fire),
    .i_periodic(1'b0),
    .i_load(mono_a_width_r),
    .o_busy(mono_a),
    .o_done()
  );

  fgt_timer #(.CW(CW)) u_mono_b (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_tick(tick_r),
    .i_start(mono_fire),
    .i_periodic(1'b0),
    .i_load(mono_b_width_r),
    .o_busy(mono_b),
    .o_done()
  );

  // Start is ignored inside the timer while a delay is pending
  fgt_timer #(.CW(CW)) u_delay (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_tick(dly_lines ? line_start : tick_r),
    .i_start(raw_trig & dly_used),
    .i_periodic(1'b0),
    .i_load(delay_count_r),
    .o_busy(dly_busy),
    .o_done(dly_done)
  );

  // Gated event counter
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      evt_cur_r <= {CW{1'b0}};
      evt_final_r <= {CW{1'b0}};
    end else if (gate) begin
      if (evt) begin
        evt_cur_r <= evt_cur_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end else if (gate_prev_r) begin
      evt_final_r <= evt_cur_r;
      evt_cur_r <= {CW{1'b0}};
    end
  end

  // Camera control port, bit by bit
  wire [CAM_BITS-1:0] cam_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < CAM_BITS; gi = gi + 1) begin : g_cam
      wire pulse_src = (gi % 2 == 1) ? mono_b : mono_a;
      assign cam_nxt[gi] = cam_out_r[gi] ? pulse_src : cam_out_r[gi+4];
    end
  endgenerate

  wire iso_nxt = sel4(iso_out_r[1:0], iso_out_r[2], mono_a, ast_pulse, acq_trig);

  // Output flops
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CAM_CTRL <= {CAM_BITS{1'b0}};
      O_EXPOSURE_SYNC_OUTPUT <= 1'b0;
      O_PIXEL_RESET_OUTPUT <= 1'b0;
      O_ISOLATED_OUTPUT_A <= 1'b0;
      O_LINE_RATE <= 1'b0;
      O_ACQ_TRIGGER <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_CAM_CTRL <= cam_nxt;
      O_EXPOSURE_SYNC_OUTPUT <= mono_a;
      O_PIXEL_RESET_OUTPUT <= mono_b;
      O_ISOLATED_OUTPUT_A <= iso_nxt;
      O_LINE_RATE <= ast_pulse;
      O_ACQ_TRIGGER <= acq_trig;
      O_IRQ <= |(irq_status_r & irq_mask_r);
    end
  end

  // Read data mux
  always @* begin
    rd_nxt = 32'h00000000;
    case (I_PADDR)
      `FGT_OFF_CTRL: rd_nxt = ctrl_r;
      `FGT_OFF_AST_PERIOD: rd_nxt = ast_period_r;
      `FGT_OFF_MONO_A_WIDTH: rd_nxt = mono_a_width_r;
      `FGT_OFF_MONO_B_WIDTH: rd_nxt = mono_b_width_r;
      `FGT_OFF_DELAY_COUNT: rd_nxt = delay_count_r;
      `FGT_OFF_EVT_CURRENT: rd_nxt = evt_cur_r;
      `FGT_OFF_EVT_FINAL: rd_nxt = evt_final_r;
      `FGT_OFF_CAM_OUT: rd_nxt[7:0] = cam_out_r;
      `FGT_OFF_ISO_OUT: rd_nxt[2:0] = iso_out_r;
      `FGT_OFF_IN_STATUS: rd_nxt[6:0] = {ast_busy, mono_b, mono_a, dly_busy, aux_in, iso_in};
      `FGT_OFF_IRQ_STATUS: rd_nxt[7:0] = irq_status_r;
      `FGT_OFF_IRQ_MASK: rd_nxt[7:0] = irq_mask_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // APB slave: ready in the first access cycle
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end else if (apb_setup) begin
      O_PREADY <= 1'b1;
      O_PSLVERR <= ~mapped(I_PADDR);
      O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_nxt;
    end else begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end
  end

  // Register writes; settings apply at once, so software changes them while idle
  always @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_r <= `FGT_RST_CTRL;
      ast_period_r <= `FGT_RST_AST_PERIOD;
      mono_a_width_r <= `FGT_RST_WIDTH;
      mono_b_width_r <= `FGT_RST_WIDTH;
      delay_count_r <= `FGT_RST_DELAY;
      cam_out_r <= `FGT_RST_CAM_OUT;
      iso_out_r <= `FGT_RST_ISO_OUT;
      irq_mask_r <= `FGT_RST_IRQ;
      irq_status_r <= `FGT_RST_IRQ;
      sw_fire_r <= 1'b0;
      sw_trig_r <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      sw_fire_r <= apb_wr && (I_PADDR == `FGT_OFF_SW_CMD) && I_PWDATA[`FGT_CMD_FIRE_MONO];
      sw_trig_r <= apb_wr && (I_PADDR == `FGT_OFF_SW_CMD) && I_PWDATA[`FGT_CMD_TRIGGER];
      if (apb_wr) begin
        case (I_PADDR)
          `FGT_OFF_CTRL: ctrl_r <= {18'h0, I_PWDATA[13:0]};
          `FGT_OFF_AST_PERIOD: ast_period_r <= I_PWDATA;
          `FGT_OFF_MONO_A_WIDTH: mono_a_width_r <= I_PWDATA;
          `FGT_OFF_MONO_B_WIDTH: mono_b_width_r <= I_PWDATA;
          `FGT_OFF_DELAY_COUNT: delay_count_r <= I_PWDATA;
          `FGT_OFF_CAM_OUT: cam_out_r <= I_PWDATA[7:0];
          `FGT_OFF_ISO_OUT: iso_out_r <= I_PWDATA[2:0];
          `FGT_OFF_IRQ_MASK: irq_mask_r <= I_PWDATA[7:0];
          default: irq_mask_r <= irq_mask_r;
        endcase
      end
    end
  end

endmodule

// ==== core/fgt_map.vh ====
// Constants for the per-channel timing and control I/O block.
// Included by the top module and the bench; definitions only.
`ifndef FGT_MAP_VH
`define FGT_MAP_VH

// Timebase
`define FGT_CLK_PERIOD_NS 8
`define FGT_TICK_NS 1000
`define FGT_TICK_CYCLES (`FGT_TICK_NS / `FGT_CLK_PERIOD_NS)

// Register byte offsets
`define FGT_OFF_CTRL 8'h00
`define FGT_OFF_AST_PERIOD 8'h04
`define FGT_OFF_MONO_A_WIDTH 8'h08
`define FGT_OFF_MONO_B_WIDTH 8'h0C
`define FGT_OFF_DELAY_COUNT 8'h10
`define FGT_OFF_EVT_CURRENT 8'h14
`define FGT_OFF_EVT_FINAL 8'h18
`define FGT_OFF_CAM_OUT 8'h1C
`define FGT_OFF_ISO_OUT 8'h20
`define FGT_OFF_IN_STATUS 8'h24
`define FGT_OFF_IRQ_STATUS 8'h28
`define FGT_OFF_IRQ_MASK 8'h2C
`define FGT_OFF_SW_CMD 8'h30

// Reset values
`define FGT_RST_CTRL 32'h00000000
`define FGT_RST_AST_PERIOD 32'h00000001
`define FGT_RST_WIDTH 32'h00000001
`define FGT_RST_DELAY 32'h00000000
`define FGT_RST_CAM_OUT 8'h00
`define FGT_RST_ISO_OUT 3'h0
`define FGT_RST_IRQ 8'h00

// Control register fields
`define FGT_CTRL_AST_EN 0
`define FGT_CTRL_MONO_SEL_LO 2
`define FGT_CTRL_DLY_LINES 4
`define FGT_CTRL_DLY_EN 5
`define FGT_CTRL_EVT_SEL_LO 6
`define FGT_CTRL_GATE_SEL_LO 8
`define FGT_CTRL_TRIG_SRC_LO 10
`define FGT_CTRL_TRIG_EDGE 12
`define FGT_CTRL_TRIG_INV 13

// Software command bits
`define FGT_CMD_FIRE_MONO 0
`define FGT_CMD_TRIGGER 1

// Interrupt status bits
`define FGT_IRQ_ACQ_DONE 0
`define FGT_IRQ_FIFO_OVF 1
`define FGT_IRQ_FRAME_START 2
`define FGT_IRQ_FRAME_END 3
`define FGT_IRQ_LINE_START 4
`define FGT_IRQ_LINE_END 5
`define FGT_IRQ_ACQ_TRIG 6
`define FGT_IRQ_TRIG_DROP 7

`endif

// ==== core/fgt_timer.v ====
// Down counter used for the astable, both monostables and the trigger delay.
// Assumes tick and start come from logic on the same clock.
`timescale 1ns/1ps
module fgt_timer #(
  parameter CW = 32
) (
  input wire i_clk, // Block clock
  input wire i_rst_n, // Async reset, active low
  input wire i_tick, // Count enable pulse
  input wire i_start, // Start request, ignored while busy
  input wire i_periodic, // Reload on expiry
  input wire [CW-1:0] i_load, // Count to run
  output wire o_busy, // High while counting
  output wire o_done // One-cycle pulse on expiry
);

  reg [CW-1:0] cnt_r;
  reg busy_r;
  reg done_r;

  assign o_busy = busy_r;
  assign o_done = done_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= {CW{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (i_start && (i_load != {CW{1'b0}})) begin
          cnt_r <= i_load;
          busy_r <= 1'b1;
        end
      end else if (i_tick) begin
        if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
          done_r <= 1'b1;
          if (i_periodic && (i_load != {CW{1'b0}})) begin
            cnt_r <= i_load;
          end else begin
            cnt_r <= {CW{1'b0}};
            busy_r <= 1'b0;
          end
        end else begin
          cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ==== dv/fgt_top_chk.sv ====
// Port-level assertions for the timing and control I/O block.
// Bound to fgt_top; one clock, async active-low reset.
`timescale 1ns/1ps
module fgt_top_chk #(
  parameter CAM_BITS = 4
) (
  input wire I_MCLK, // Clock
  input wire I_RESET_N, // Reset
  input wire I_PSEL, // Select
  input wire I_PENABLE, // Enable
  input wire I_PWRITE, // Direction
  input wire [31:0] O_PRDATA, // Read data
  input wire O_PREADY, // Ready
  input wire O_PSLVERR, // Error
  input wire [CAM_BITS-1:0] O_CAM_CTRL, // Camera port
  input wire O_LINE_RATE, // Astable pulse
  input wire O_ACQ_TRIGGER, // Trigger pulse
  input wire O_IRQ // Interrupt
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  ready_one_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  setup_answer_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  ready_cause_a: assert property (
    O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PSEL && !I_PENABLE))
    else $error("ready without transfer");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error outside access");
  rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside access");
  line_pulse_a: assert property (O_LINE_RATE |=> !O_LINE_RATE)
    else $error("line rate pulse too long");
  irq_clear_a: assert property (
    $fell(O_IRQ) |-> $past(O_PREADY && I_PWRITE) || $past(O_PREADY && I_PWRITE, 2))
    else $error("interrupt fell without write");
  reset_outs_a: assert property ($rose(I_RESET_N) |->
    O_CAM_CTRL == '0 && !O_IRQ && !O_LINE_RATE && !O_ACQ_TRIGGER)
    else $error("outputs not idle after reset");
endmodule
bind fgt_top fgt_top_chk #(.CAM_BITS(CAM_BITS)) i_fgt_top_chk (.I_MCLK, .I_RESET_N,
  .I_PSEL, .I_PENABLE, .I_PWRITE, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_CAM_CTRL,
  .O_LINE_RATE, .O_ACQ_TRIGGER, .O_IRQ);

// ==== dv/fgt_cam_model.sv ====
// Camera, trigger sensor and aux input model for the timing block.
// Driven by task calls from the bench; every task except line starts at a rising edge.
`timescale 1ns/1ps
module fgt_cam_model (
  input wire i_clk, // Block clock
  output logic o_line_valid, // Line valid
  output logic o_frame_valid, // Frame valid
  output logic o_iso, // Isolated input
  output logic [1:0] o_aux // Aux inputs
);
  initial begin
    o_line_valid = 1'b0;
    o_frame_valid = 1'b0;
    o_iso = 1'b0;
    o_aux = 2'h0;
  end
  task line();
    o_line_valid <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_line_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  // Two stray lines outside the frame, then nl framed lines
  task frame(input int nl);
    @(posedge i_clk);
    repeat (2) line();
    o_frame_valid <= 1'b1;
    repeat (2) @(posedge i_clk);
    repeat (nl) line();
    o_frame_valid <= 1'b0;
  endtask
  task pulse_iso();
    @(posedge i_clk);
    o_iso <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_iso <= 1'b0;
  endtask
  task set_in(input logic i, input logic [1:0] x);
    @(posedge i_clk);
    o_iso <= i;
    o_aux <= x;
  endtask
endmodule

// ==== dv/fgt_top_test.sv ====
// Self-checking bench for the timing and control I/O block.
// Uses APB tasks, the camera model and a shortened microsecond tick.
`timescale 1ns/1ps
`include "fgt_map.vh"
module fgt_top_test;
  localparam int TC = 4;
  logic clk, rst_n, psel, pen, pwr, acq_done, fifo_ovf, re, acq_act;
  logic [7:0] padr;
  logic [31:0] pwd, rq;
  wire [31:0] prdata;
  wire [3:0] cam;
  wire [1:0] aux;
  wire pready, pslverr, lval, fval, iso_in, es, pr, iso_out, lr, at, irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  fgt_top #(.TICK_CYCLES(TC)) i_fgt_top (.I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LINE_VALID(lval), .I_FRAME_VALID(fval),
    .I_ISOLATED_INPUT_A(iso_in), .I_DIFF_AUX_INPUT(aux), .I_ACQ_ACTIVE(acq_act),
    .I_ACQ_DONE(acq_done), .I_FIFO_OVERFLOW(fifo_ovf), .O_CAM_CTRL(cam),
    .O_EXPOSURE_SYNC_OUTPUT(es), .O_PIXEL_RESET_OUTPUT(pr), .O_ISOLATED_OUTPUT_A(iso_out),
    .O_LINE_RATE(lr), .O_ACQ_TRIGGER(at), .O_IRQ(irq));
  fgt_cam_model i_fgt_cam_model (.i_clk(clk), .o_line_valid(lval), .o_frame_valid(fval),
    .o_iso(iso_in), .o_aux(aux));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task chkr(input string nm, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      n_mismatch++;
    end
  endtask
  // One transfer; request held until ready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Read before this edge's updates land
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task t_regs();
    rd(`FGT_OFF_CTRL); chk("ctrl", `FGT_RST_CTRL, rq);
    rd(`FGT_OFF_AST_PERIOD); chk("period", `FGT_RST_AST_PERIOD, rq);
    rd(`FGT_OFF_MONO_B_WIDTH); chk("width", `FGT_RST_WIDTH, rq);
    rd(`FGT_OFF_DELAY_COUNT); chk("delay", `FGT_RST_DELAY, rq);
    wr(`FGT_OFF_CTRL, 32'hFFFFFFFF);
    rd(`FGT_OFF_CTRL); chk("ctrl bits", 32'h00003FFF, rq);
    wr(`FGT_OFF_CTRL, 32'h0);
    rd(8'h3C); chk("unmapped err", 32'h1, {31'h0, re});
  endtask
  task t_io();
    wr(`FGT_OFF_CAM_OUT, 32'h000000A0);
    wt(3); chk("cam level", 32'hA, {28'h0, cam});
    wr(`FGT_OFF_ISO_OUT, 32'h00000004);
    wt(3); chk("iso level", 32'h1, {31'h0, iso_out});
    i_fgt_cam_model.set_in(1'b1, 2'b10);
    wt(5); rd(`FGT_OFF_IN_STATUS); chk("inputs", 32'h5, {29'h0, rq[2:0]});
    i_fgt_cam_model.set_in(1'b0, 2'b01);
    wt(5); rd(`FGT_OFF_IN_STATUS); chk("inputs", 32'h2, {29'h0, rq[2:0]});
  endtask
  task t_mono();
    int na, nb, ni, nf;
    na = 0;
    nb = 0;
    ni = 0;
    nf = 0;
    wr(`FGT_OFF_MONO_A_WIDTH, 32'h3);
    wr(`FGT_OFF_MONO_B_WIDTH, 32'h5);
    wr(`FGT_OFF_CTRL, 32'h0000000C);
    wr(`FGT_OFF_CAM_OUT, 32'h0000000F);
    wr(`FGT_OFF_ISO_OUT, 32'h00000001);
    wr(`FGT_OFF_SW_CMD, 32'h1);
    repeat (40) begin
      @(negedge clk);
      if (es === 1'b1) na++;
      if (pr === 1'b1) nb++;
      if (iso_out === 1'b1) ni++;
      if (cam === 4'hF) nf++;
    end
    chkr("mono a", 2 * TC, 4 * TC, na);
    chkr("mono b", 4 * TC, 6 * TC, nb);
    chkr("iso timer", na, na, ni);
    chkr("cam pulses", na - 2, na + 2, nf);
  endtask
  task t_ast();
    int t[3];
    int k;
    for (int p = 1; p <= 5; p += 4) begin
      t = '{0, 0, 0};
      k = 0;
      wr(`FGT_OFF_AST_PERIOD, p);
      wr(`FGT_OFF_CTRL, 32'h1);
      for (int i = 0; i < 200 && k < 3; i++) begin
        @(negedge clk);
        if (lr === 1'b1) begin
          t[k] = i;
          k++;
        end
      end
      chkr("ast period", p * TC, p * TC, t[2] - t[1]);
      wr(`FGT_OFF_CTRL, 32'h0);
      wt(6 * TC);
    end
  endtask
  task t_dly();
    int k, t0;
    k = 0;
    t0 = 0;
    wr(`FGT_OFF_IRQ_STATUS, 32'hFF);
    wr(`FGT_OFF_DELAY_COUNT, 32'd10);
    wr(`FGT_OFF_CTRL, 32'h00001020);
    fork
      begin
        i_fgt_cam_model.pulse_iso();
        repeat (8) @(posedge clk);
        i_fgt_cam_model.pulse_iso();
        repeat (50) @(posedge clk);
        i_fgt_cam_model.pulse_iso();
      end
      for (int i = 0; i < 140; i++) begin
        @(negedge clk);
        if (at === 1'b1) begin
          if (k == 0) t0 = i;
          k++;
        end
      end
    join
    chkr("delay time", 9 * TC, 14 * TC, t0);
    chkr("trigger count", 2, 2, k);
    rd(`FGT_OFF_IRQ_STATUS); chk("drop irq", 32'hC0, rq & 32'hC0);
  endtask
  task t_evt();
    wr(`FGT_OFF_CTRL, 32'h00000100);
    wr(`FGT_OFF_IRQ_STATUS, 32'hFF);
    i_fgt_cam_model.frame(5);
    wt(6);
    rd(`FGT_OFF_EVT_FINAL); chk("final count", 32'h5, rq);
    rd(`FGT_OFF_EVT_CURRENT); chk("running count", 32'h0, rq);
    rd(`FGT_OFF_IRQ_STATUS); chk("video irq", 32'h3C, rq & 32'h3C);
  endtask
  // Microseconds counted while the acquisition is active
  task t_gate();
    wr(`FGT_OFF_CTRL, 32'h00000380);
    @(posedge clk);
    acq_act <= 1'b1;
    repeat (10 * TC) @(posedge clk);
    acq_act <= 1'b0;
    wt(3);
    rd(`FGT_OFF_EVT_FINAL);
    chk("us count", 32'd10, rq);
  endtask
  // Software trigger delayed by two line starts, not by microseconds
  task t_dlyl();
    int k;
    k = 0;
    wr(`FGT_OFF_DELAY_COUNT, 32'd2);
    wr(`FGT_OFF_CTRL, 32'h00000030);
    wr(`FGT_OFF_SW_CMD, 32'h2);
    repeat (6 * TC) begin
      @(negedge clk);
      if (at === 1'b1) k++;
    end
    chk("no line yet", 32'h0, k);
    fork
      i_fgt_cam_model.frame(0);
      repeat (40) begin
        @(negedge clk);
        if (at === 1'b1) k++;
      end
    join
    chk("line delay", 32'h1, k);
  endtask
  task t_irq();
    wr(`FGT_OFF_IRQ_STATUS, 32'hFF);
    @(posedge clk);
    acq_done <= 1'b1;
    fifo_ovf <= 1'b1;
    @(posedge clk);
    acq_done <= 1'b0;
    fifo_ovf <= 1'b0;
    wt(2); chk("masked irq", 32'h0, {31'h0, irq});
    wr(`FGT_OFF_IRQ_STATUS, 32'h1);
    rd(`FGT_OFF_IRQ_STATUS); chk("w1c", 32'h2, rq & 32'h3);
    wr(`FGT_OFF_IRQ_MASK, 32'h2);
    wt(3); chk("irq on", 32'h1, {31'h0, irq});
    wr(`FGT_OFF_IRQ_STATUS, 32'h2);
    wt(3); chk("irq off", 32'h0, {31'h0, irq});
  endtask
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; padr = 8'h00; pwd = 32'h0;
    acq_done = 1'b0;
    fifo_ovf = 1'b0;
    acq_act = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_io();
    t_mono();
    t_ast();
    t_dly();
    t_evt();
    t_gate();
    t_dlyl();
    t_irq();
    end_of_test();
  end
endmodule
